// ==== rtl/subtract_borrow_literal_exec.sv ====
// Execution datapath for the two subtract instructions, with APB register access
//
// Notes on behaviour
// - Register-borrow subtract: accumulator minus file register minus inverted carry, 8 bits.
// - Destination bit zero: the difference goes to the accumulator, the file register is kept.
// - Destination bit one: the difference is written back to the addressed file register.
// - Bank-mode bit zero: the 8-bit operand address is resolved inside the access bank.
// - Bank-mode bit one: the bank select register chooses the general purpose register bank.
// - Bank-mode zero, extended set on, address up to 95: indexed literal offset addressing.
// - The immediate subtract computes the 8-bit instruction literal minus the accumulator.
// - The immediate subtract always writes the accumulator and never a file register.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "subtract_borrow_literal_exec_consts.svh"

module subtract_borrow_literal_exec #(
  parameter int BANK_BITS = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core state view
  output logic [7:0] acc_value,
  output logic [4:0] status_flags,
  output logic exec_done,
  output subtract_exec_pkg::op_t last_op
);
  import subtract_exec_pkg::*;

  // ==========================================================
  // Geometry
  localparam int ADDR_W = 8 + BANK_BITS;
  localparam int DEPTH = 1 << ADDR_W;

  generate
    if (BANK_BITS < 1 || BANK_BITS > 4)
    begin : g_bad_banks
      $error("BANK_BITS must lie between 1 and 4");
    end
  endgenerate

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] instr;
    logic [7:0] acc;
    logic [4:0] flags;
    logic [BANK_BITS-1:0] bank_select_register;
    logic ext_en;
    logic [ADDR_W-1:0] index_base;
    logic [ADDR_W-1:0] mem_addr;
    logic pending;
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic illegal;
    logic done;
    logic [7:0] exec_count;
    op_t last_op;
  } state_t;

  state_t state;
  state_t next_state;

  // File registers
  logic [7:0] file_mem [DEPTH];
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [ADDR_W-1:0] eff_addr;
  logic [7:0] operand;
  logic [7:0] mem_view;

  // ==========================================================
  // Functions
  function automatic op_t decode(input logic [15:0] word);
    op_t op;
    op = OP_NONE;
    if (word[15:10] == `OPC_REG_BORROW)
    begin
      op = OP_REG_BORROW;
    end
    else if (word[15:8] == `OPC_IMMEDIATE)
    begin
      op = OP_IMMEDIATE;
    end
    return op;
  endfunction

  function automatic logic [ADDR_W-1:0] resolve_addr(
    input logic bank_mode,
    input logic [7:0] f,
    input logic [BANK_BITS-1:0] bank,
    input logic ext,
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W-1:0] a;
    a = {bank, f};
    if (!bank_mode)
    begin
      if (f <= `ACCESS_LOW_LAST)
      begin
        if (ext)
        begin
          a = ADDR_W'(base + ADDR_W'(f));
        end
        else
        begin
          a = ADDR_W'(f);
        end
      end
      else
      begin
        a = {{BANK_BITS{1'b1}}, f};
      end
    end
    return a;
  endfunction

  // Computes x + ~y + cin: carry set means no borrow
  function automatic result_t sub_core(
    input logic [7:0] x,
    input logic [7:0] y,
    input logic cin
  );
    result_t r;
    logic [8:0] sum;
    logic [4:0] nib;
    sum = {1'b0, x} + {1'b0, ~y} + {8'h00, cin};
    nib = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + {4'h0, cin};
    r.value = sum[7:0];
    r.flags = '0;
    r.flags[`FLAG_CARRY] = sum[8];
    r.flags[`FLAG_DIGIT_CARRY] = nib[4];
    r.flags[`FLAG_ZERO] = (sum[7:0] == 8'h00);
    r.flags[`FLAG_OVERFLOW] = (x[7] != y[7]) && (sum[7] != x[7]);
    r.flags[`FLAG_NEGATIVE] = sum[7];
    return r;
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    logic m;
    unique case (a)
      `OFS_INSTR, `OFS_ACC, `OFS_FLAGS, `OFS_BANK, `OFS_CONFIG,
      `OFS_INDEX_BASE, `OFS_MEM_ADDR, `OFS_MEM_DATA, `OFS_EXEC_STATUS:
        m = 1'b1;
      default:
        m = 1'b0;
    endcase
    return m;
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Operand fetch
  assign eff_addr = resolve_addr(state.instr[`INSTR_BANKMODE_BIT], state.instr[7:0],
                                 state.bank_select_register, state.ext_en, state.index_base);
  assign operand = file_mem[eff_addr];
  assign mem_view = file_mem[state.mem_addr];

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [31:0] rd;
    logic [31:0] wr;
    result_t res;
    op_t op;
    rd = 32'h0000_0000;
    wr = 32'h0000_0000;
    res = '0;
    op = decode(state.instr);
    next_state = state;
    next_state.done = 1'b0;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = 8'h00;

    // Execute the latched instruction in one cycle
    if (state.pending)
    begin
      next_state.pending = 1'b0;
      next_state.done = 1'b1;
      next_state.last_op = op;
      next_state.illegal = 1'b0;
      next_state.exec_count = 8'(state.exec_count + 8'h01);
      unique case (op)
        OP_REG_BORROW:
        begin
          res = sub_core(state.acc, operand, state.flags[`FLAG_CARRY]);
          next_state.flags = res.flags;
          if (state.instr[`INSTR_DEST_BIT])
          begin
            mem_we = 1'b1;
            mem_wa = eff_addr;
            mem_wd = res.value;
          end
          else
          begin
            next_state.acc = res.value;
          end
        end
        OP_IMMEDIATE:
        begin
          res = sub_core(state.instr[7:0], state.acc, 1'b1);
          next_state.flags = res.flags;
          next_state.acc = res.value;
        end
        OP_NONE:
        begin
          next_state.illegal = 1'b1;
        end
      endcase
    end

    // APB: first access cycle captures read data, second completes
    rd[7:0] = state.acc;
    unique case (paddr)
      `OFS_INSTR: rd = {16'h0000, state.instr};
      `OFS_ACC: rd = {24'h000000, state.acc};
      `OFS_FLAGS: rd = {27'h0000000, state.flags};
      `OFS_BANK: rd = 32'(state.bank_select_register);
      `OFS_CONFIG: rd = {31'h00000000, state.ext_en};
      `OFS_INDEX_BASE: rd = 32'(state.index_base);
      `OFS_MEM_ADDR: rd = 32'(state.mem_addr);
      `OFS_MEM_DATA: rd = {24'h000000, mem_view};
      `OFS_EXEC_STATUS: rd = {16'h0000, state.exec_count, 6'h00, state.illegal, state.done};
      default: rd = 32'h0000_0000;
    endcase

    if (psel && penable)
    begin
      if (!state.ack && !state.pending)
      begin
        next_state.ack = 1'b1;
        next_state.err = !is_mapped(paddr);
        next_state.rdata = pwrite ? 32'h0000_0000 : rd;
      end
      else if (state.ack)
      begin
        next_state.ack = 1'b0;
        next_state.err = 1'b0;
        if (pwrite && is_mapped(paddr))
        begin
          wr = merge(rd, pwdata, pstrb);
          unique case (paddr)
            `OFS_INSTR:
            begin
              next_state.instr = wr[15:0];
              next_state.pending = 1'b1;
            end
            `OFS_ACC: next_state.acc = wr[7:0];
            `OFS_FLAGS: next_state.flags = wr[4:0];
            `OFS_BANK: next_state.bank_select_register = wr[BANK_BITS-1:0];
            `OFS_CONFIG: next_state.ext_en = wr[`CFG_EXT_BIT];
            `OFS_INDEX_BASE: next_state.index_base = wr[ADDR_W-1:0];
            `OFS_MEM_ADDR: next_state.mem_addr = wr[ADDR_W-1:0];
            `OFS_MEM_DATA:
            begin
              mem_we = 1'b1;
              mem_wa = state.mem_addr;
              mem_wd = wr[7:0];
            end
            default:
            begin
            end
          endcase
        end
      end
    end
    else
    begin
      next_state.ack = 1'b0;
      next_state.err = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= '0;
      state.instr <= `RST_INSTR;
      state.acc <= `RST_ACC;
      state.flags <= `RST_FLAGS;
      state.exec_count <= `RST_COUNT;
      state.last_op <= OP_NONE;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (mem_we)
    begin
      file_mem[mem_wa] <= mem_wd;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = state.rdata;
  assign pready = state.ack;
  assign pslverr = state.ack & state.err;
  assign acc_value = state.acc;
  assign status_flags = state.flags;
  assign exec_done = state.done;
  assign last_op = state.last_op;

endmodule

// ==== rtl/subtract_borrow_literal_exec_consts.svh ====
// Offsets, field positions, encodings and reset values of the subtract execution block
`ifndef SUBTRACT_BORROW_LITERAL_EXEC_CONSTS_SVH
`define SUBTRACT_BORROW_LITERAL_EXEC_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define OFS_INSTR 12'h000
`define OFS_ACC 12'h004
`define OFS_FLAGS 12'h008
`define OFS_BANK 12'h00C
`define OFS_CONFIG 12'h010
`define OFS_INDEX_BASE 12'h014
`define OFS_MEM_ADDR 12'h018
`define OFS_MEM_DATA 12'h01C
`define OFS_EXEC_STATUS 12'h020

// ==========================================================
// Flag bit positions
`define FLAG_CARRY 0
`define FLAG_DIGIT_CARRY 1
`define FLAG_ZERO 2
`define FLAG_OVERFLOW 3
`define FLAG_NEGATIVE 4
`define FLAGS_W 5

// ==========================================================
// Other field positions
`define CFG_EXT_BIT 0
`define EXEC_DONE_BIT 0
`define EXEC_ILLEGAL_BIT 1
`define EXEC_COUNT_LSB 8
`define INSTR_DEST_BIT 9
`define INSTR_BANKMODE_BIT 8

// ==========================================================
// Instruction encodings
`define OPC_REG_BORROW 6'h15
`define OPC_IMMEDIATE 8'h08
`define ACCESS_LOW_LAST 8'h5F

// ==========================================================
// Reset values
`define RST_INSTR 16'h0000
`define RST_ACC 8'h00
`define RST_FLAGS 5'h00
`define RST_COUNT 8'h00

`endif

// ==== rtl/subtract_exec_pkg.sv ====
// Types shared by the subtract execution block
package subtract_exec_pkg;

  // ==========================================================
  // Decoded operation, one-hot
  typedef enum logic [2:0] {
    OP_NONE = 3'b001,
    OP_REG_BORROW = 3'b010,
    OP_IMMEDIATE = 3'b100
  } op_t;

  // ==========================================================
  // Arithmetic result: value and new flags
  typedef struct packed {
    logic [7:0] value;
    logic [4:0] flags;
  } result_t;

endpackage

// ==== tb/subtract_borrow_literal_exec_tb_top.sv ====
// Self-checking bench for the subtract execution block
`timescale 1ns/1ps
`include "subtract_borrow_literal_exec_consts.svh"

module subtract_borrow_literal_exec_tb_top;
  import subtract_exec_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic exec_done;
  logic [7:0] acc_value;
  logic [4:0] status_flags;
  op_t last_op;
  int n_errors = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic er;

  always #12.5 pclk = ~pclk;

  subtract_borrow_literal_exec #(.BANK_BITS(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc_value(acc_value), .status_flags(status_flags),
    .exec_done(exec_done), .last_op(last_op)
  );

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (exec_done !== 1'b1 && n < 8)
    begin
      @(posedge pclk);
      n++;
    end
    check(32'(n), 32'h1);
  endtask

  // Flags of x - y - !c from integer arithmetic: carry and digit carry mean no borrow
  function automatic logic [4:0] sub_flags(input logic [7:0] x, input logic [7:0] y,
    input logic c);
    int d;
    int sd;
    logic [7:0] v;
    logic ov;
    logic dc;
    d = int'(x) - int'(y) - int'(!c);
    sd = int'($signed(x)) - int'($signed(y)) - int'(!c);
    v = 8'(d);
    ov = (sd < -128) || (sd > 127);
    dc = (int'(x[3:0]) - int'(y[3:0]) - int'(!c)) >= 0;
    return {v[7], ov, v == 8'h00, dc, d >= 0};
  endfunction

  task automatic run_borrow(input logic [11:0] ma, input logic [9:0] daf,
    input logic [7:0] rv, input logic [7:0] w, input logic c);
    logic [7:0] res;
    res = w - rv - {7'h0, !c};
    apb(1'b1, `OFS_MEM_ADDR, 32'(ma));
    apb(1'b1, `OFS_MEM_DATA, 32'(rv));
    apb(1'b1, `OFS_ACC, 32'(w));
    apb(1'b1, `OFS_FLAGS, 32'(c));
    apb(1'b1, `OFS_INSTR, {16'h0, `OPC_REG_BORROW, daf});
    wait_done();
    rchk(`OFS_ACC, 32'(daf[9] ? w : res));
    rchk(`OFS_MEM_DATA, 32'(daf[9] ? res : rv));
    rchk(`OFS_FLAGS, 32'(sub_flags(w, rv, c)));
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_literal();
    logic [7:0] ws[4] = '{8'h01, 8'h02, 8'h03, 8'h80};
    apb(1'b1, `OFS_MEM_ADDR, 32'h002);
    apb(1'b1, `OFS_MEM_DATA, 32'h5A);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `OFS_ACC, 32'(ws[i]));
      apb(1'b1, `OFS_INSTR, {16'h0, `OPC_IMMEDIATE, 8'h02});
      wait_done();
      check(32'(acc_value), 32'(8'(8'h02 - ws[i])));
      check(32'(status_flags), 32'(sub_flags(8'h02, ws[i], 1'b1)));
      check(32'(last_op), 32'(OP_IMMEDIATE));
    end
    rchk(`OFS_MEM_DATA, 32'h5A);
    $display("test literal done");
  endtask

  task automatic test_dest();
    run_borrow(12'h020, {2'b10, 8'h20}, 8'h03, 8'h02, 1'b1);
    run_borrow(12'h020, {2'b00, 8'h20}, 8'h02, 8'h05, 1'b1);
    run_borrow(12'h020, {2'b10, 8'h20}, 8'h01, 8'h02, 1'b0);
    $display("test destination done");
  endtask

  task automatic test_banks();
    apb(1'b1, `OFS_BANK, 32'h2);
    run_borrow(12'h233, {2'b01, 8'h33}, 8'h10, 8'h80, 1'b1);
    run_borrow(12'hF80, {2'b10, 8'h80}, 8'h7F, 8'h00, 1'b1);
    apb(1'b1, `OFS_CONFIG, 32'h1);
    apb(1'b1, `OFS_INDEX_BASE, 32'h300);
    run_borrow(12'h233, {2'b11, 8'h33}, 8'h05, 8'h09, 1'b0);
    run_borrow(12'h35F, {2'b10, 8'h5F}, 8'h01, 8'h01, 1'b1);
    run_borrow(12'hF60, {2'b10, 8'h60}, 8'h00, 8'h00, 1'b0);
    apb(1'b1, `OFS_CONFIG, 32'h0);
    $display("test banks done");
  endtask

  task automatic test_illegal();
    apb(1'b1, `OFS_ACC, 32'h44);
    apb(1'b1, `OFS_INSTR, 32'h5C00);
    wait_done();
    check(32'(last_op), 32'(OP_NONE));
    rchk(`OFS_ACC, 32'h44);
    pstrb <= 4'h0;
    apb(1'b1, `OFS_ACC, 32'h99);
    pstrb <= 4'hF;
    rchk(`OFS_ACC, 32'h44);
    apb(1'b0, `OFS_EXEC_STATUS, 32'h0);
    check(32'(rd[1]), 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    check(32'(er), 32'h1);
    check(rd, 32'h0);
    $display("test illegal done");
  endtask

  task automatic test_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'(acc_value), 32'(`RST_ACC));
    check(32'(status_flags), 32'(`RST_FLAGS));
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(last_op), 32'(OP_NONE));
    check(32'(exec_done), 32'h0);
    apb(1'b1, `OFS_INSTR, {16'h0, `OPC_IMMEDIATE, 8'h02});
    wait_done();
    check(32'(acc_value), 32'h02);
    rchk(`OFS_EXEC_STATUS, 32'h0000_0100);
    $display("test reset done");
  endtask

  // ==========================================================
  // Sequence and verdict
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(last_op), 32'(OP_NONE));
    test_literal();
    test_dest();
    test_banks();
    test_illegal();
    test_reset();
    tally_and_finish();
  end

  initial
  begin
    #50000;
    n_errors++;
    tally_and_finish();
  end
endmodule

// ==== tb/subtract_exec_sva.sv ====
// Concurrent checks on the subtract execution block ports
`timescale 1ns/1ps
`include "subtract_borrow_literal_exec_consts.svh"

module subtract_exec_sva #(
  parameter int BANK_BITS = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  // Core state
  input wire logic [7:0] acc_value,
  input wire logic [4:0] status_flags,
  input wire logic exec_done,
  input wire subtract_exec_pkg::op_t last_op
);
  import subtract_exec_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Instruction writes
  sequence instr_wr;
    psel && penable && pready && pwrite && paddr == `OFS_INSTR && pstrb == 4'hF;
  endsequence
  sequence imm_wr;
    instr_wr ##0 pwdata[15:8] == `OPC_IMMEDIATE;
  endsequence
  sequence brw_wr;
    instr_wr ##0 pwdata[15:10] == `OPC_REG_BORROW;
  endsequence

  // ==========================================================
  // Properties
  chk_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_done_pulse: assert property (
    instr_wr |=> !exec_done ##1 exec_done ##1 !exec_done)
    else $error("exec_done timing wrong");
  chk_imm_acc: assert property (
    imm_wr |-> ##2 acc_value == 8'($past(pwdata[7:0], 2) - $past(acc_value, 2)))
    else $error("immediate result wrong");
  chk_imm_carry: assert property (
    imm_wr |-> ##2 status_flags[0] == ($past(pwdata[7:0], 2) >= $past(acc_value, 2)))
    else $error("immediate carry wrong");
  chk_imm_op: assert property (imm_wr |-> ##2 last_op == OP_IMMEDIATE)
    else $error("immediate not decoded");
  chk_brw_op: assert property (brw_wr |-> ##2 last_op == OP_REG_BORROW)
    else $error("borrow subtract not decoded");
  chk_dest_file: assert property (brw_wr ##0 pwdata[9] |-> ##2 $stable(acc_value))
    else $error("accumulator written for file destination");
  chk_imm_nz: assert property (
    exec_done && last_op == OP_IMMEDIATE |->
      status_flags[4] == acc_value[7] && status_flags[2] == (acc_value == 8'h00))
    else $error("immediate zero or negative flag wrong");
endmodule

bind subtract_borrow_literal_exec subtract_exec_sva #(.BANK_BITS(BANK_BITS)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .acc_value(acc_value),
  .status_flags(status_flags), .exec_done(exec_done), .last_op(last_op)
);
